// ### iobsr_pkg.sv
// Constants and carrier types for the low I/O bit-access and scratch register bank
package iobsr_pkg;

  // ----------------------------------------------------------------
  // Register addresses in I/O space
  // ----------------------------------------------------------------
  localparam logic [5:0] IOBSR_STATUS_ADDR = 6'h15;
  localparam logic [5:0] IOBSR_SCRATCH0_ADDR = 6'h1e;
  localparam logic [5:0] IOBSR_SCRATCH1_ADDR = 6'h2a;
  localparam logic [5:0] IOBSR_SCRATCH2_ADDR = 6'h2b;
  localparam logic [5:0] IOBSR_BITOP_LAST = 6'h1f;

  // ----------------------------------------------------------------
  // Values after reset and for unmapped reads
  // ----------------------------------------------------------------
  localparam logic [7:0] IOBSR_SCRATCH_RESET = 8'h00;
  localparam logic [7:0] IOBSR_STATUS_RESET = 8'h00;
  localparam logic [7:0] IOBSR_UNMAPPED_READ = 8'h00;

  // ----------------------------------------------------------------
  // Operations issued by the core
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    IOBSR_IDLE_OP = 3'b000,
    IOBSR_WRITE_OP = 3'b001,
    IOBSR_READ_OP = 3'b010,
    IOBSR_SET_IO_BIT_OP = 3'b011,
    IOBSR_CLEAR_IO_BIT_OP = 3'b100,
    IOBSR_SKIP_IF_IO_BIT_SET_OP = 3'b101,
    IOBSR_SKIP_IF_IO_BIT_CLEAR_OP = 3'b110
  } iobsr_op_t;

  typedef struct packed {
    iobsr_op_t op;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [2:0] bit_sel;
  } iobsr_req_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic skip;
    logic done;
  } iobsr_rsp_t;

  typedef struct packed {
    logic [2:0][7:0] scratch;
    logic [7:0] status;
    iobsr_rsp_t rsp;
  } iobsr_state_t;

endpackage

// ### iobsr_bank.sv
// Low I/O register bank: single-bit access, bit tests, write-one-to-clear flags, scratch registers
`timescale 1ns/10ps
module iobsr_bank (
  input wire logic CLOCK,
  input wire logic NRST,
  input wire logic CE,
  input wire iobsr_pkg::iobsr_req_t REQ,
  input wire logic [7:0] FLAG_EVENT,
  output iobsr_pkg::iobsr_rsp_t RSP
);

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  function automatic logic [7:0] iobsr_read(input iobsr_pkg::iobsr_state_t s, input logic [5:0] a);
    logic [7:0] v;
    case (a)
      iobsr_pkg::IOBSR_STATUS_ADDR: v = s.status;
      iobsr_pkg::IOBSR_SCRATCH0_ADDR: v = s.scratch[0];
      iobsr_pkg::IOBSR_SCRATCH1_ADDR: v = s.scratch[1];
      iobsr_pkg::IOBSR_SCRATCH2_ADDR: v = s.scratch[2];
      default: v = iobsr_pkg::IOBSR_UNMAPPED_READ;
    endcase
    return v;
  endfunction

  iobsr_pkg::iobsr_state_t state_reg;
  iobsr_pkg::iobsr_state_t state_next;
  logic [7:0] cur;
  logic [7:0] mask;
  logic [7:0] wval;
  logic wr;
  logic low_addr;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    cur = iobsr_read(state_reg, REQ.addr);
    mask = 8'h01 << REQ.bit_sel;
    wval = 8'h00;
    wr = 1'b0;
    low_addr = (REQ.addr <= iobsr_pkg::IOBSR_BITOP_LAST);
    if (CE) begin
      state_next.rsp.done = (REQ.op != iobsr_pkg::IOBSR_IDLE_OP);
      case (REQ.op)
        iobsr_pkg::IOBSR_WRITE_OP: begin
          wval = REQ.wdata;
          wr = 1'b1;
        end
        iobsr_pkg::IOBSR_READ_OP: begin
          state_next.rsp.rdata = cur;
        end
        iobsr_pkg::IOBSR_SET_IO_BIT_OP: begin
          // Status gets a lone one on the addressed bit; others get their read value with that bit set
          if (REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR) begin
            wval = mask;
          end else begin
            wval = cur | mask;
          end
          wr = low_addr;
        end
        iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP: begin
          if (REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR) begin
            wval = 8'h00;
          end else begin
            wval = cur & ~mask;
          end
          wr = low_addr;
        end
        iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_SET_OP: begin
          state_next.rsp.skip = low_addr & |(cur & mask);
        end
        iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_CLEAR_OP: begin
          state_next.rsp.skip = low_addr & ~|(cur & mask);
        end
        default: begin
          wr = 1'b0;
        end
      endcase
      if (wr) begin
        case (REQ.addr)
          iobsr_pkg::IOBSR_STATUS_ADDR: state_next.status = state_reg.status & ~wval;
          iobsr_pkg::IOBSR_SCRATCH0_ADDR: state_next.scratch[0] = wval;
          iobsr_pkg::IOBSR_SCRATCH1_ADDR: state_next.scratch[1] = wval;
          iobsr_pkg::IOBSR_SCRATCH2_ADDR: state_next.scratch[2] = wval;
          default: state_next.status = state_reg.status;
        endcase
      end
      // A flag raised in the cycle it is cleared survives
      state_next.status = state_next.status | FLAG_EVENT;
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK or negedge NRST) begin
    if (!NRST) begin
      state_reg.scratch <= {3{iobsr_pkg::IOBSR_SCRATCH_RESET}};
      state_reg.status <= iobsr_pkg::IOBSR_STATUS_RESET;
      state_reg.rsp <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign RSP = state_reg.rsp;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (!NRST);

  a_w1c_flag_clear: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_WRITE_OP && REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR && FLAG_EVENT == 8'h00
    |=> state_reg.status == ($past(state_reg.status) & ~$past(REQ.wdata)))
    else $error("status write did not clear the flags written with one");

  a_w1c_zero_hold: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_WRITE_OP && REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR
    && REQ.wdata == 8'h00 && FLAG_EVENT == 8'h00
    |=> $stable(state_reg.status))
    else $error("writing zero changed a status flag");

  a_bitset_single_bit: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_SET_IO_BIT_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH0_ADDR
    |=> ((state_reg.scratch[0] ^ $past(state_reg.scratch[0])) & ~(8'h01 << $past(REQ.bit_sel))) == 8'h00
    && state_reg.scratch[0][$past(REQ.bit_sel)])
    else $error("bit set disturbed another bit or missed its own");

  a_bitop_status_flags: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_SET_IO_BIT_OP && REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR && FLAG_EVENT == 8'h00
    |=> state_reg.status == ($past(state_reg.status) & ~(8'h01 << $past(REQ.bit_sel))))
    else $error("bit set on status cleared more than the addressed flag");

  a_bitop_high_addr: assert property (
    CE && (REQ.op == iobsr_pkg::IOBSR_SET_IO_BIT_OP || REQ.op == iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP)
    && REQ.addr > iobsr_pkg::IOBSR_BITOP_LAST && FLAG_EVENT == 8'h00
    |=> $stable(state_reg.scratch) && $stable(state_reg.status))
    else $error("bit operation above 0x1f changed a register");

  a_scratch_write_read: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_WRITE_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH1_ADDR
    ##1 CE && REQ.op == iobsr_pkg::IOBSR_READ_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH1_ADDR
    |=> RSP.rdata == $past(REQ.wdata, 2) && RSP.done)
    else $error("scratch register did not return the written value");

  a_skip_bit_test: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_CLEAR_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH0_ADDR
    |=> RSP.skip == !$past(state_reg.scratch[0][REQ.bit_sel]))
    else $error("skip test result does not match the tested bit");

  a_bitclr_single_bit: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH0_ADDR
    |=> ((state_reg.scratch[0] ^ $past(state_reg.scratch[0])) & ~(8'h01 << $past(REQ.bit_sel))) == 8'h00
    && !state_reg.scratch[0][$past(REQ.bit_sel)])
    else $error("bit clear disturbed another bit or missed its own");

  a_bitclr_status_hold: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP && REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR && FLAG_EVENT == 8'h00
    |=> $stable(state_reg.status))
    else $error("bit clear on status changed a flag");

  a_skip_set_test: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_SET_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH0_ADDR
    |=> RSP.skip == $past(state_reg.scratch[0][REQ.bit_sel]))
    else $error("skip if set result does not match the tested bit");

  a_skip_high_zero: assert property (
    CE && (REQ.op == iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_SET_OP || REQ.op == iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_CLEAR_OP)
    && REQ.addr > iobsr_pkg::IOBSR_BITOP_LAST |=> !RSP.skip)
    else $error("skip test above 0x1f did not return zero");

  a_flag_event_set: assert property (
    CE && FLAG_EVENT != 8'h00
    |=> (state_reg.status & $past(FLAG_EVENT)) == $past(FLAG_EVENT))
    else $error("a raised flag event was lost");

  a_status_read_value: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_READ_OP && REQ.addr == iobsr_pkg::IOBSR_STATUS_ADDR
    |=> RSP.rdata == $past(state_reg.status))
    else $error("status read returned a wrong value");

  a_scratch2_write_read: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_WRITE_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH2_ADDR
    ##1 CE && REQ.op == iobsr_pkg::IOBSR_READ_OP && REQ.addr == iobsr_pkg::IOBSR_SCRATCH2_ADDR
    |=> RSP.rdata == $past(REQ.wdata, 2) && RSP.done)
    else $error("third scratch register did not return the written value");

  a_ce_low_freeze: assert property (
    !CE
    |=> $stable(state_reg))
    else $error("state changed while the clock enable was low");

  a_done_after_op: assert property (
    CE && REQ.op != iobsr_pkg::IOBSR_IDLE_OP
    |=> RSP.done)
    else $error("done did not follow a taken operation");

  a_idle_no_done: assert property (
    CE && REQ.op == iobsr_pkg::IOBSR_IDLE_OP
    |=> !RSP.done)
    else $error("done raised after an idle cycle");

  a_scratch0_no_side: assert property (
    CE && (REQ.addr != iobsr_pkg::IOBSR_SCRATCH0_ADDR || REQ.op inside {iobsr_pkg::IOBSR_READ_OP,
    iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_SET_OP, iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_CLEAR_OP, iobsr_pkg::IOBSR_IDLE_OP})
    |=> $stable(state_reg.scratch[0]))
    else $error("first scratch register changed without a write to it");

  a_scratch1_no_side: assert property (
    CE && (REQ.addr != iobsr_pkg::IOBSR_SCRATCH1_ADDR || REQ.op != iobsr_pkg::IOBSR_WRITE_OP)
    |=> $stable(state_reg.scratch[1]))
    else $error("second scratch register changed without a write to it");

  a_scratch2_no_side: assert property (
    CE && (REQ.addr != iobsr_pkg::IOBSR_SCRATCH2_ADDR || REQ.op != iobsr_pkg::IOBSR_WRITE_OP)
    |=> $stable(state_reg.scratch[2]))
    else $error("third scratch register changed without a write to it");

endmodule // iobsr_bank

// ### iobsr_core.sv
// Processor core model issuing I/O requests to the register bank
`timescale 1ns/10ps
module iobsr_core (
  input wire logic CLOCK,
  output iobsr_pkg::iobsr_req_t REQ,
  output logic CE
);
  initial begin
    REQ = '0;
    CE = 1'b0;
  end
  // ----------------------------------------------------------------
  // One request per rising edge, held until the next call
  // ----------------------------------------------------------------
  task automatic issue(iobsr_pkg::iobsr_op_t o, logic [5:0] a, logic [7:0] w, logic [2:0] b, logic en);
    @(posedge CLOCK);
    CE <= en;
    REQ <= '{o, a, w, b};
  endtask
endmodule // iobsr_core

// ### io_bit_access_scratch_regs_test.sv
// Self-checking bench for the low I/O bit-access register bank
`timescale 1ns/10ps
`define IOBSR_CHECK(n, e, g) begin checks++; if ((g) !== (e)) begin failures++; $display("unexpected %s exp %h got %h", n, e, g); end end
module io_bit_access_scratch_regs_test;
  localparam iobsr_pkg::iobsr_op_t RD = iobsr_pkg::IOBSR_READ_OP;
  localparam iobsr_pkg::iobsr_op_t WR = iobsr_pkg::IOBSR_WRITE_OP;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] flag_event = 8'h00;
  logic ce;
  iobsr_pkg::iobsr_req_t req;
  iobsr_pkg::iobsr_rsp_t rsp;
  logic [8:0] exp_q[$];
  logic [8:0] e;
  logic [5:0] adr [4] = '{iobsr_pkg::IOBSR_SCRATCH0_ADDR, iobsr_pkg::IOBSR_SCRATCH1_ADDR,
    iobsr_pkg::IOBSR_SCRATCH2_ADDR, iobsr_pkg::IOBSR_STATUS_ADDR};
  logic [7:0] regs [5] = '{default: iobsr_pkg::IOBSR_SCRATCH_RESET};
  logic [7:0] exp_rd = 8'h00;
  logic exp_sk = 1'b0;
  int failures = 0;
  int checks = 0;
  logic ce_seen = 1'b0;
  iobsr_core iobsr_core_i (.CLOCK(clock), .REQ(req), .CE(ce));
  iobsr_bank iobsr_bank_i (.CLOCK(clock), .NRST(nrst), .CE(ce), .REQ(req), .FLAG_EVENT(flag_event), .RSP(rsp));
  initial forever #10 clock = ~clock;
  // ----------------------------------------------------------------
  // Reference model and expectation queue
  // ----------------------------------------------------------------
  task automatic op(iobsr_pkg::iobsr_op_t o, logic [5:0] a, logic [7:0] w = 8'h00, logic [2:0] b = 3'h0,
    logic en = 1'b1);
    int s;
    logic ok;
    s = 4;
    for (int i = 0; i < 4; i++) if (adr[i] == a) s = i;
    ok = a <= iobsr_pkg::IOBSR_BITOP_LAST;
    regs[4] = iobsr_pkg::IOBSR_UNMAPPED_READ;
    if (en) begin
      case (o)
        RD: exp_rd = regs[s];
        WR: regs[s] = (s == 3) ? regs[3] & ~w : w;
        iobsr_pkg::IOBSR_SET_IO_BIT_OP: if (ok) regs[s] = (s == 3) ? regs[3] & ~(8'h01 << b) : regs[s] | (8'h01 << b);
        iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP: if (ok && s < 3) regs[s][b] = 1'b0;
        iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_SET_OP: exp_sk = ok & regs[s][b];
        iobsr_pkg::IOBSR_SKIP_IF_IO_BIT_CLEAR_OP: exp_sk = ok & ~regs[s][b];
        default: ;
      endcase
      if (o != iobsr_pkg::IOBSR_IDLE_OP) exp_q.push_back({exp_rd, exp_sk});
    end
    iobsr_core_i.issue(o, a, w, b, en);
  endtask
  // A cycle with the enable low freezes the response, so only taken cycles yield a fresh result
  always @(posedge clock) ce_seen <= ce;
  always @(negedge clock) begin
    if (rsp.done === 1'b1 && ce_seen === 1'b1) begin
      if (exp_q.size() == 0) `IOBSR_CHECK("done", 1'b0, rsp.done)
      else begin
        e = exp_q.pop_front();
        `IOBSR_CHECK("rdata", e[8:1], rsp.rdata)
        `IOBSR_CHECK("skip", e[0], rsp.skip)
      end
    end
  end
  task automatic conclude();
    if (failures == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #100us;
    failures++;
    conclude();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    void'($urandom(92737));
    repeat (12) @(posedge clock);
    nrst <= 1'b1;
    for (int i = 0; i < 5; i++) op(RD, (i < 4) ? adr[i] : 6'h00);
    for (int i = 0; i < 3; i++) begin
      op(WR, adr[i], 8'($urandom));
      op(RD, adr[i]);
    end
    repeat (24) begin
      op(iobsr_pkg::iobsr_op_t'(3'(3 + $urandom % 4)), adr[2 * ($urandom % 2)], 8'h00, 3'($urandom));
      op(RD, adr[0]);
    end
    op(RD, adr[2]);
    op(iobsr_pkg::IOBSR_IDLE_OP, 6'h00);
    @(posedge clock) flag_event <= 8'hff;
    regs[3] = 8'hff;
    @(posedge clock) flag_event <= 8'h00;
    op(WR, adr[3], 8'h00);
    op(RD, adr[3]);
    op(WR, adr[3], 8'h81);
    op(RD, adr[3]);
    fork
      op(WR, adr[3], 8'h06);
      @(posedge clock) flag_event <= 8'h02;
    join
    regs[3] = regs[3] | 8'h02;
    fork
      op(RD, adr[3]);
      @(posedge clock) flag_event <= 8'h00;
    join
    op(iobsr_pkg::IOBSR_SET_IO_BIT_OP, adr[3], 8'h00, 3'h3);
    op(iobsr_pkg::IOBSR_CLEAR_IO_BIT_OP, adr[3], 8'h00, 3'h2);
    op(RD, adr[3]);
    op(WR, adr[1], 8'h3c, 3'h0, 1'b0);
    op(RD, adr[1]);
    op(iobsr_pkg::IOBSR_IDLE_OP, 6'h00);
    repeat (4) @(posedge clock);
    `IOBSR_CHECK("pending", 0, exp_q.size())
    conclude();
  end
endmodule // io_bit_access_scratch_regs_test
